// file: include/oag_pkg.sv
// Constants for the operand address generator: opcode rows, operation
// nibbles, addressing mode codes and multiply sequencing figures.
// Assumes the opcode map of an 8-bit accumulator/index CPU core.
package oag_pkg;

  // ==========================================================================
  // Opcode rows (upper nibble of the opcode byte).
  localparam logic [3:0] ROW_BIT_BRANCH = 4'h0;
  localparam logic [3:0] ROW_BIT_SETCLR = 4'h1;
  localparam logic [3:0] ROW_REL        = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR    = 4'h3;
  localparam logic [3:0] ROW_INH_ACC    = 4'h4;
  localparam logic [3:0] ROW_INH_IDX    = 4'h5;
  localparam logic [3:0] ROW_RMW_IX1    = 4'h6;
  localparam logic [3:0] ROW_RMW_IX     = 4'h7;
  localparam logic [3:0] ROW_CTRL_LO    = 4'h8;
  localparam logic [3:0] ROW_CTRL_HI    = 4'h9;
  localparam logic [3:0] ROW_IMM        = 4'hA;
  localparam logic [3:0] ROW_DIR        = 4'hB;
  localparam logic [3:0] ROW_EXT        = 4'hC;
  localparam logic [3:0] ROW_IX2        = 4'hD;
  localparam logic [3:0] ROW_IX1        = 4'hE;
  localparam logic [3:0] ROW_IX         = 4'hF;

  // ==========================================================================
  // Register/memory operations (lower nibble of the opcode byte).
  localparam logic [3:0] OP_SUB = 4'h0;
  localparam logic [3:0] OP_CMP = 4'h1;
  localparam logic [3:0] OP_SBC = 4'h2;
  localparam logic [3:0] OP_CPX = 4'h3;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_LDA = 4'h6;
  localparam logic [3:0] OP_STA = 4'h7;
  localparam logic [3:0] OP_EOR = 4'h8;
  localparam logic [3:0] OP_ADC = 4'h9;
  localparam logic [3:0] OP_ORA = 4'hA;
  localparam logic [3:0] OP_ADD = 4'hB;
  localparam logic [3:0] OP_JMP = 4'hC;
  localparam logic [3:0] OP_JSR = 4'hD;
  localparam logic [3:0] OP_LDX = 4'hE;
  localparam logic [3:0] OP_STX = 4'hF;

  // Whole opcodes with a meaning of their own.
  localparam logic [7:0] UNSIGNED_MULTIPLY_OP = 8'h42;
  localparam logic [7:0] BRANCH_SUBR_OP       = 8'hAD;

  // ==========================================================================
  // Addressing mode codes reported with each decoded instruction.
  localparam logic [2:0] MODE_INH = 3'h0;
  localparam logic [2:0] MODE_IMM = 3'h1;
  localparam logic [2:0] MODE_DIR = 3'h2;
  localparam logic [2:0] MODE_EXT = 3'h3;
  localparam logic [2:0] MODE_IX  = 3'h4;
  localparam logic [2:0] MODE_IX1 = 3'h5;
  localparam logic [2:0] MODE_IX2 = 3'h6;
  localparam logic [2:0] MODE_REL = 3'h7;

  // Instruction lengths in bytes.
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================================
  // Multiply sequencing: load, eight add-shift steps, write-back, finish.
  localparam int         MUL_CYCLES     = 11;
  localparam logic [3:0] MUL_STEP_FIRST = 4'h1;
  localparam logic [3:0] MUL_STEP_LAST  = 4'h8;
  localparam logic [3:0] MUL_WRITEBACK  = 4'h9;
  localparam logic [3:0] MUL_FINISH     = 4'(MUL_CYCLES - 1);

  // Fixed upper byte for page-zero addresses.
  localparam logic [7:0] PAGE_ZERO = 8'h00;

endpackage : oag_pkg

// file: tb/oag_decoder_sva.sv
// Checker for the operand address generator, attached to the decoder by bind.
// Assumes the decoder ports and the mode and length codes of oag_pkg.
`timescale 1ns/100ps

module oag_decoder_sva (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        byte_ready,
  input wire logic        instr_done,
  input wire logic [2:0]  instr_mode,
  input wire logic [1:0]  instr_len,
  input wire logic [15:0] oper_addr,
  input wire logic        oper_addr_valid,
  input wire logic        mul_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Multiply sequencing.
  a_mul_eleven: assert property ($rose(mul_busy) |-> mul_busy[*8] ##1 mul_busy[*3] ##1 !mul_busy)
    else $error("multiply busy span is not eleven cycles");
  a_busy_stall: assert property (mul_busy |-> !byte_ready)
    else $error("byte stream open while multiply runs");
  a_mul_ends: assert property ($fell(mul_busy) |-> instr_done && byte_ready)
    else $error("multiply end without completion pulse");

  // ==========================================================================
  // Lengths and address shapes per addressing mode.
  a_inh_short: assert property (instr_done && instr_mode == oag_pkg::MODE_INH |->
    instr_len == oag_pkg::LEN_ONE && !oper_addr_valid) else $error("inherent form wrong");
  a_imm_short: assert property (instr_done && instr_mode == oag_pkg::MODE_IMM |->
    instr_len == oag_pkg::LEN_TWO && !oper_addr_valid) else $error("immediate form wrong");
  a_dir_page: assert property (oper_addr_valid && instr_mode == oag_pkg::MODE_DIR |->
    oper_addr[15:8] == oag_pkg::PAGE_ZERO) else $error("direct address above page zero");
  a_ext_three: assert property (instr_done && instr_mode == oag_pkg::MODE_EXT |->
    instr_len == oag_pkg::LEN_THREE && oper_addr_valid) else $error("extended form wrong");
  a_ix_page: assert property (oper_addr_valid && instr_mode == oag_pkg::MODE_IX |->
    oper_addr[15:8] == 8'h00 && instr_len == oag_pkg::LEN_ONE) else $error("indexed form wrong");
  a_ix1_reach: assert property (oper_addr_valid && instr_mode == oag_pkg::MODE_IX1 |->
    oper_addr[15:9] == 7'h00 && instr_len == oag_pkg::LEN_TWO) else $error("offset form wrong");
endmodule : oag_decoder_sva

bind oag_decoder oag_decoder_sva u_sva (.ref_clk(ref_clk), .reset(reset),
  .byte_ready(byte_ready), .instr_done(instr_done), .instr_mode(instr_mode),
  .instr_len(instr_len), .oper_addr(oper_addr), .oper_addr_valid(oper_addr_valid),
  .mul_busy(mul_busy));

// file: tb/oag_prog_src.sv
// Program memory model that offers the instruction byte stream.
// Assumes the bench queues bytes through push; slow inserts a gap after each byte.
`timescale 1ns/100ps

module oag_prog_src (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       byte_ready,
  input  wire logic       slow,
  output logic            byte_valid,
  output logic      [7:0] byte_data
);
  logic [7:0] fifo[$];
  logic [7:0] last;
  logic       gap;
  logic       rdy_seen;

  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask : push

  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h5A;
    last = 8'h5A;
    gap = 1'b0;
  end

  // Ready is looked at mid-cycle so the edge update cannot race the take.
  always @(negedge ref_clk) begin
    rdy_seen = byte_ready;
  end

  // Pops a taken byte; an idle data line shows a changing pattern, not the old byte.
  always @(posedge ref_clk) begin
    if (byte_valid && rdy_seen && fifo.size() > 0) begin
      last = fifo.pop_front();
      gap = slow;
    end else begin
      gap = 1'b0;
    end
    #1;
    byte_valid = !reset && !gap && fifo.size() > 0;
    byte_data = byte_valid ? fifo[0] : ~last;
    last = byte_data;
  end
endmodule : oag_prog_src

// file: tb/tb.sv
// Self-checking bench for the operand address generator.
// Assumes the program memory model and the checker are compiled before it.
`timescale 1ns/100ps

module tb;
  logic        ref_clk, reset, byte_valid, byte_ready, branch_cond, carry_in, slow;
  logic        ext_acc_wr, ext_idx_wr, instr_done, instr_illegal, oper_addr_valid;
  logic        imm_valid, branch_taken, mul_busy;
  logic [7:0]  byte_data, ext_wr_data, instr_opcode, imm_data, acc, idx;
  logic [15:0] pc_next, oper_addr, branch_target;
  logic [2:0]  instr_mode;
  logic [1:0]  instr_len;
  int          failures, n_checks, n_stall;

  oag_decoder uut (.ref_clk, .reset, .byte_valid, .byte_data, .byte_ready, .pc_next,
    .branch_cond, .carry_in, .ext_acc_wr, .ext_idx_wr, .ext_wr_data, .instr_done,
    .instr_opcode, .instr_mode, .instr_len, .instr_illegal, .oper_addr, .oper_addr_valid,
    .imm_data, .imm_valid, .branch_target, .branch_taken, .acc, .idx, .mul_busy);
  oag_prog_src u_mem (.ref_clk, .reset, .byte_ready, .slow, .byte_valid, .byte_data);

  // ==========================================================================
  // Clock, reset and watchdog.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #800000;
    failures++;
    give_verdict();
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for the completion pulse and counts refused cycles on the way.
  task automatic wait_done();
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      #1;
      if (byte_ready === 1'b0) n_stall++;
      if (instr_done === 1'b1) break;
    end
    if (k == 40) failures++;
  endtask : wait_done

  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input int n);
    u_mem.push(b0);
    if (n > 1) u_mem.push(b1);
    if (n > 2) u_mem.push(b2);
    wait_done();
  endtask : run

  task automatic set_regs(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    #1 {ext_wr_data, ext_acc_wr} = {a, 1'b1};
    @(posedge ref_clk);
    #1 {ext_wr_data, ext_acc_wr, ext_idx_wr} = {x, 2'b01};
    @(posedge ref_clk);
    #1 ext_idx_wr = 1'b0;
  endtask : set_regs

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Scenarios.
  task automatic t_imm();
    logic [3:0] ok[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                           4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};
    run(8'hA6, 8'h5A, 8'h00, 2);
    chk(acc, 16'h005A);
    chk({imm_valid, imm_data, instr_opcode}, {1'b1, 8'h5A, 8'hA6});
    chk(instr_mode, oag_pkg::MODE_IMM);
    run(8'hA0, 8'h6B, 8'h00, 2);
    chk(acc, 16'h00EF);
    carry_in = 1'b1;
    run(8'hA2, 8'h01, 8'h00, 2);
    chk(acc, 16'h00ED);
    run(8'hA9, 8'h10, 8'h00, 2);
    chk(acc, 16'h00FE);
    carry_in = 1'b0;
    run(8'hA7, 8'h33, 8'h00, 2);
    chk(instr_illegal, 1'b1);
    chk(acc, 16'h00FE);
    foreach (ok[i]) begin
      run({4'hA, ok[i]}, 8'h0F, 8'h00, 2);
      chk(instr_illegal, 1'b0);
    end
  endtask : t_imm

  task automatic t_dir();
    logic [3:0] rmw[11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8,
                            4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
    for (int n = 0; n < 16; n++) begin
      run({4'hB, 4'(n)}, {4'(n), 4'hC}, 8'h00, 2);
      chk(oper_addr, {8'h00, 4'(n), 4'hC});
      chk(instr_len, oag_pkg::LEN_TWO);
    end
    foreach (rmw[i]) begin
      run({4'h3, rmw[i]}, 8'hFF, 8'h00, 2);
      chk({instr_mode, oper_addr}, {oag_pkg::MODE_DIR, 16'h00FF});
    end
    run(8'h17, 8'h80, 8'h00, 2);
    chk({instr_mode, oper_addr}, {oag_pkg::MODE_DIR, 16'h0080});
  endtask : t_dir

  task automatic t_ext();
    slow = 1'b1;
    for (int n = 0; n < 16; n++) begin
      run({4'hC, 4'(n)}, {4'(n), 4'h1}, 8'hA5, 3);
      chk(oper_addr, {4'(n), 12'h1A5});
      chk(instr_illegal, 1'b0);
    end
    slow = 1'b0;
    run(8'hC6, 8'h12, 8'h34, 3);
    u_mem.push(8'hCD);
    u_mem.push(8'hFF);
    u_mem.push(8'hFE);
    chk(oper_addr, 16'h1234);
    wait_done();
    chk(oper_addr, 16'hFFFE);
  endtask : t_ext

  task automatic t_ix();
    set_regs(8'h00, 8'hFF);
    run(8'hF6, 8'h00, 8'h00, 1);
    chk({instr_mode, oper_addr}, {oag_pkg::MODE_IX, 16'h00FF});
    run(8'hE6, 8'hFF, 8'h00, 2);
    chk({instr_mode, oper_addr}, {oag_pkg::MODE_IX1, 16'h01FE});
    run(8'h7C, 8'h00, 8'h00, 1);
    chk(oper_addr, 16'h00FF);
    set_regs(8'h00, 8'h01);
    run(8'h6C, 8'h80, 8'h00, 2);
    chk(oper_addr, 16'h0081);
    run(8'hD6, 8'h12, 8'hFF, 3);
    chk({instr_mode, oper_addr}, {oag_pkg::MODE_IX2, 16'h1300});
  endtask : t_ix

  task automatic t_branch();
    pc_next = 16'h0200;
    branch_cond = 1'b1;
    run(8'h01, 8'h40, 8'h10, 3);
    chk({oper_addr, branch_target}, 32'h0040_0210);
    chk({branch_taken, instr_len}, {1'b1, oag_pkg::LEN_THREE});
    pc_next = 16'h0300;
    run(8'h20, 8'hF0, 8'h00, 2);
    chk(branch_target, 16'h02F0);
    run(8'h20, 8'h7F, 8'h00, 2);
    chk(branch_target, 16'h037F);
    branch_cond = 1'b0;
    run(8'h26, 8'h10, 8'h00, 2);
    chk(branch_taken, 1'b0);
  endtask : t_branch

  task automatic t_inh();
    logic [7:0] ops[16] = '{8'h48, 8'h58, 8'h4F, 8'h53, 8'h4C, 8'h5A, 8'h40, 8'h4D,
                            8'h98, 8'h9A, 8'h9C, 8'h80, 8'h83, 8'h97, 8'h9F, 8'h8E};
    foreach (ops[i]) begin
      run(ops[i], 8'h00, 8'h00, 1);
      chk({instr_mode, instr_len}, {oag_pkg::MODE_INH, oag_pkg::LEN_ONE});
      chk(oper_addr_valid, 1'b0);
    end
  endtask : t_inh

  task automatic t_mul(input logic [7:0] a, input logic [7:0] x);
    set_regs(a, x);
    n_stall = 0;
    u_mem.push(oag_pkg::UNSIGNED_MULTIPLY_OP);
    u_mem.push(8'h9D);
    wait_done();
    chk(n_stall, oag_pkg::MUL_CYCLES);
    chk({idx, acc}, a * x);
    wait_done();
    chk({idx, acc}, a * x);
  endtask : t_mul

  // ==========================================================================
  // Main sequence.
  initial begin
    {reset, branch_cond, carry_in, slow, ext_acc_wr, ext_idx_wr} = 6'b100000;
    {ext_wr_data, pc_next} = 24'h0;
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_imm();
    t_dir();
    t_ext();
    t_ix();
    t_branch();
    t_inh();
    t_mul(8'hC8, 8'h0F);
    t_mul(8'hFF, 8'hFF);
    give_verdict();
  end
endmodule : tb

// file: verilog/oag_adder.sv
// Adder used for the immediate, multiply and index sums in the block: addition, and subtraction by
// adding the inverted second operand with a carry in.
// Assumes purely combinational use by the operand address generator.
`timescale 1ns/100ps

module oag_adder #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         sub,
  input  wire logic         cin,
  output logic      [W-1:0] sum,
  output logic              cout
);

  // ==========================================================================
  // Single adder path; subtraction only inverts the second operand.
  logic [W-1:0] b_eff;

  always_comb begin
    b_eff       = sub ? ~b : b;
    {cout, sum} = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, cin};
  end

endmodule : oag_adder

// file: verilog/oag_decoder.sv
// Instruction length decoder and operand address generator, holding the
// accumulator and index registers and sequencing the unsigned multiply.
// Assumes a byte stream from program memory on ref_clk, with the fetch
// logic giving the address after the current instruction on pc_next.
//
// How it works
// RQ1: Multiply takes exactly eleven cycles.
// RQ2: Multiply iterates add and shift steps.
// RQ3: Subtract adds the inverted operand plus carry.
// RQ4: Eight addressing modes are decoded.
// RQ5: Inherent is one byte, no address.
// RQ6: Inherent covers register and control operations.
// RQ7: Immediate takes second byte, two bytes, no address.
// RQ8: Immediate only for arithmetic, logic, compare, loads.
// RQ9: Direct address is zero high, second byte low.
// RQ10: Bit branches: direct address, then displacement.
// RQ11: Direct covers memory, read-modify-write, bits, jumps.
// RQ12: Extended takes high then low address byte.
// RQ13: Extended excludes read-modify-write operations.
// RQ14: Indexed no offset uses index as low byte.
// RQ15: Indexed offset adds index, carry is bit eight.
// RQ16: Taken branch adds signed displacement to counter.
// RQ17: Multiply puts high byte in index, low in accumulator.
// RQ18: Every operand address is sixteen bits; direct, IX and IX1 forms are zero extended.
`timescale 1ns/100ps

module oag_decoder (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  input  wire logic [15:0] pc_next,
  input  wire logic        branch_cond,
  input  wire logic        carry_in,
  input  wire logic        ext_acc_wr,
  input  wire logic        ext_idx_wr,
  input  wire logic [7:0]  ext_wr_data,
  output logic             instr_done,
  output logic [7:0]       instr_opcode,
  output logic [2:0]       instr_mode,
  output logic [1:0]       instr_len,
  output logic             instr_illegal,
  output logic [15:0]      oper_addr,
  output logic             oper_addr_valid,
  output logic [7:0]       imm_data,
  output logic             imm_valid,
  output logic [15:0]      branch_target,
  output logic             branch_taken,
  output logic [7:0]       acc,
  output logic [7:0]       idx,
  output logic             mul_busy
);

  // ==========================================================================
  // State encoding and the whole state of the block.
  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_BYTE1  = 4'b0010,
    ST_BYTE2  = 4'b0100,
    ST_MUL    = 4'b1000
  } oag_state_t;

  typedef struct packed {
    oag_state_t  fsm;
    logic [7:0]  opcode;
    logic [2:0]  mode;
    logic [1:0]  len;
    logic        illegal;
    logic [7:0]  b1;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [3:0]  cnt;
    logic [7:0]  mcand;
    logic [15:0] prod;
    logic        done;
    logic [15:0] addr;
    logic        addr_valid;
    logic [7:0]  imm;
    logic        imm_valid;
    logic [15:0] target;
    logic        taken;
  } oag_regs_t;

  oag_regs_t r;
  oag_regs_t n;

  // ==========================================================================
  // Opcode decode: addressing mode, length and legality from the opcode byte.
  logic [2:0] dec_mode;
  logic [1:0] dec_len;
  logic       dec_illegal;
  logic [3:0] op_row;
  logic [3:0] op_lo;

  always_comb begin
    op_row      = byte_data[7:4];
    op_lo       = byte_data[3:0];
    dec_mode    = oag_pkg::MODE_INH;
    dec_len     = oag_pkg::LEN_ONE;
    dec_illegal = 1'b0;
    unique case (op_row)
      // Register and control operations, one byte, no memory address.
      oag_pkg::ROW_INH_ACC, oag_pkg::ROW_INH_IDX,
      oag_pkg::ROW_CTRL_LO, oag_pkg::ROW_CTRL_HI: begin
        dec_mode = oag_pkg::MODE_INH; // RQ5 RQ6
        dec_len  = oag_pkg::LEN_ONE;
      end
      oag_pkg::ROW_BIT_BRANCH: begin
        dec_mode = oag_pkg::MODE_DIR; // RQ10
        dec_len  = oag_pkg::LEN_THREE;
      end
      // Bit set/clear, read-modify-write and plain direct memory forms.
      oag_pkg::ROW_BIT_SETCLR, oag_pkg::ROW_RMW_DIR, oag_pkg::ROW_DIR: begin
        dec_mode = oag_pkg::MODE_DIR; // RQ11
        dec_len  = oag_pkg::LEN_TWO;
      end
      oag_pkg::ROW_REL: begin
        dec_mode = oag_pkg::MODE_REL;
        dec_len  = oag_pkg::LEN_TWO;
      end
      oag_pkg::ROW_IMM: begin
        dec_len = oag_pkg::LEN_TWO; // RQ7
        if (byte_data == oag_pkg::BRANCH_SUBR_OP) begin
          dec_mode = oag_pkg::MODE_REL;
        end else begin
          dec_mode    = oag_pkg::MODE_IMM;
          dec_illegal = (op_lo == oag_pkg::OP_STA) || (op_lo == oag_pkg::OP_STX)
                        || (op_lo == oag_pkg::OP_JMP); // RQ8
        end
      end
      oag_pkg::ROW_EXT: begin
        dec_mode = oag_pkg::MODE_EXT; // RQ12 RQ13
        dec_len  = oag_pkg::LEN_THREE;
      end
      oag_pkg::ROW_IX2: begin
        dec_mode = oag_pkg::MODE_IX2; // RQ4
        dec_len  = oag_pkg::LEN_THREE;
      end
      oag_pkg::ROW_IX1, oag_pkg::ROW_RMW_IX1: begin
        dec_mode = oag_pkg::MODE_IX1;
        dec_len  = oag_pkg::LEN_TWO;
      end
      oag_pkg::ROW_IX, oag_pkg::ROW_RMW_IX: begin
        dec_mode = oag_pkg::MODE_IX; // RQ14
        dec_len  = oag_pkg::LEN_ONE;
      end
    endcase
  end

  // ==========================================================================
  // Shared adders: immediate arithmetic, multiply step and index sums.
  logic [7:0]  alu_a;
  logic        alu_sub;
  logic        alu_cin;
  logic [7:0]  alu_sum;
  logic [7:0]  mul_b;
  logic [7:0]  mul_sum;
  logic        mul_cout;
  logic [7:0]  ix1_sum;
  logic        ix1_cout;
  logic [15:0] ix2_sum;
  logic [3:0]  cur_lo;

  // Subtract forms feed the inverted operand and a carry into the adder.
  always_comb begin
    cur_lo  = r.opcode[3:0];
    alu_a   = (cur_lo == oag_pkg::OP_CPX) ? r.idx : r.acc;
    alu_sub = (cur_lo == oag_pkg::OP_SUB) || (cur_lo == oag_pkg::OP_CMP)
              || (cur_lo == oag_pkg::OP_SBC) || (cur_lo == oag_pkg::OP_CPX); // RQ3
    unique case (cur_lo)
      oag_pkg::OP_SBC: alu_cin = ~carry_in;
      oag_pkg::OP_ADC: alu_cin = carry_in;
      oag_pkg::OP_ADD: alu_cin = 1'b0;
      default:         alu_cin = alu_sub;
    endcase
    mul_b = r.prod[0] ? r.mcand : 8'h00; // RQ2
  end

  oag_adder #(.W(8)) u_alu (
    .a    (alu_a),
    .b    (byte_data),
    .sub  (alu_sub),
    .cin  (alu_cin),
    .sum  (alu_sum),
    .cout ()
  );

  oag_adder #(.W(8)) u_mul (
    .a    (r.prod[15:8]),
    .b    (mul_b),
    .sub  (1'b0),
    .cin  (1'b0),
    .sum  (mul_sum),
    .cout (mul_cout)
  );

  oag_adder #(.W(8)) u_ix1 (
    .a    (r.idx),
    .b    (byte_data),
    .sub  (1'b0),
    .cin  (1'b0),
    .sum  (ix1_sum),
    .cout (ix1_cout)
  );

  oag_adder #(.W(16)) u_ix2 (
    .a    ({r.b1, byte_data}),
    .b    ({oag_pkg::PAGE_ZERO, r.idx}),
    .sub  (1'b0),
    .cin  (1'b0),
    .sum  (ix2_sum),
    .cout ()
  );

  // Relative target from the address after the instruction.
  logic [15:0] rel_target;

  always_comb begin
    rel_target = pc_next + {{8{byte_data[7]}}, byte_data}; // RQ16
  end

  // ==========================================================================
  // Next-state logic: byte-by-byte decode, address forming and multiply.
  always_comb begin
    n            = r;
    n.done       = 1'b0;
    n.addr_valid = 1'b0;
    n.imm_valid  = 1'b0;
    n.taken      = 1'b0;
    if (ext_acc_wr && (r.fsm != ST_MUL)) begin
      n.acc = ext_wr_data;
    end
    if (ext_idx_wr && (r.fsm != ST_MUL)) begin
      n.idx = ext_wr_data;
    end
    unique case (r.fsm)
      ST_OPCODE: begin
        if (byte_valid) begin
          n.opcode  = byte_data;
          n.mode    = dec_mode;
          n.len     = dec_len;
          n.illegal = dec_illegal;
          n.target  = 16'h0000;
          if (byte_data == oag_pkg::UNSIGNED_MULTIPLY_OP) begin
            n.fsm = ST_MUL; // RQ1
            n.cnt = 4'h0;
          end else if (dec_len != oag_pkg::LEN_ONE) begin
            n.fsm = ST_BYTE1;
          end else begin
            n.done = 1'b1; // RQ5
            n.addr = {oag_pkg::PAGE_ZERO, r.idx}; // RQ14 RQ18
            n.addr_valid = (dec_mode == oag_pkg::MODE_IX);
          end
        end
      end
      ST_BYTE1: begin
        if (byte_valid) begin
          n.b1 = byte_data;
          if (r.len == oag_pkg::LEN_THREE) begin
            n.fsm = ST_BYTE2;
            n.addr = {oag_pkg::PAGE_ZERO, byte_data}; // RQ10
          end else begin
            n.fsm  = ST_OPCODE;
            n.done = 1'b1;
            unique case (r.mode)
              oag_pkg::MODE_IMM: begin
                n.imm       = byte_data; // RQ7
                n.imm_valid = 1'b1;
                if (!r.illegal) begin
                  unique case (cur_lo)
                    oag_pkg::OP_LDA: n.acc = byte_data;
                    oag_pkg::OP_LDX: n.idx = byte_data;
                    oag_pkg::OP_AND: n.acc = r.acc & byte_data;
                    oag_pkg::OP_ORA: n.acc = r.acc | byte_data;
                    oag_pkg::OP_EOR: n.acc = r.acc ^ byte_data;
                    oag_pkg::OP_ADD, oag_pkg::OP_ADC,
                    oag_pkg::OP_SUB, oag_pkg::OP_SBC: n.acc = alu_sum; // RQ3
                    default: n.acc = n.acc;
                  endcase
                end
              end
              oag_pkg::MODE_DIR: begin
                n.addr       = {oag_pkg::PAGE_ZERO, byte_data}; // RQ9 RQ18
                n.addr_valid = 1'b1;
              end
              oag_pkg::MODE_IX1: begin
                n.addr       = {7'h00, ix1_cout, ix1_sum}; // RQ15 RQ18
                n.addr_valid = 1'b1;
              end
              oag_pkg::MODE_REL: begin
                n.target = rel_target; // RQ16
                n.taken  = branch_cond;
              end
              default: n.addr_valid = 1'b0;
            endcase
          end
        end
      end
      ST_BYTE2: begin
        if (byte_valid) begin
          n.fsm        = ST_OPCODE;
          n.done       = 1'b1;
          n.addr_valid = 1'b1;
          unique case (r.mode)
            oag_pkg::MODE_EXT: n.addr = {r.b1, byte_data}; // RQ12
            oag_pkg::MODE_IX2: n.addr = ix2_sum; // RQ4
            default: begin
              n.target = rel_target; // RQ10 RQ16
              n.taken  = branch_cond;
            end
          endcase
        end
      end
      ST_MUL: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'h0) begin
          n.mcand = r.idx;
          n.prod  = {8'h00, r.acc};
        end else if (r.cnt <= oag_pkg::MUL_STEP_LAST) begin
          n.prod = {mul_cout, mul_sum, r.prod[7:1]}; // RQ2
        end else if (r.cnt == oag_pkg::MUL_WRITEBACK) begin
          n.idx = r.prod[15:8]; // RQ17
          n.acc = r.prod[7:0];
        end else begin
          n.fsm  = ST_OPCODE; // RQ1
          n.done = 1'b1;
          n.cnt  = 4'h0;
        end
      end
    endcase
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{fsm: ST_OPCODE, default: '0};
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs; the fetch side is held off while the multiply runs.
  assign byte_ready      = (r.fsm != ST_MUL); // RQ1
  assign mul_busy        = (r.fsm == ST_MUL);
  assign instr_done      = r.done;
  assign instr_opcode    = r.opcode;
  assign instr_mode      = r.mode;
  assign instr_len       = r.len;
  assign instr_illegal   = r.illegal;
  assign oper_addr       = r.addr;
  assign oper_addr_valid = r.addr_valid;
  assign imm_data        = r.imm;
  assign imm_valid       = r.imm_valid;
  assign branch_target   = r.target;
  assign branch_taken    = r.taken;
  assign acc             = r.acc;
  assign idx             = r.idx;

endmodule : oag_decoder
